/* src/fnc_pkg.sv */
// Constants and types for the float not-equal compare unit
package fnc_pkg;
    localparam int WORD_W = 32;
    localparam int FLAG_W = 7;
    localparam int EV_W = 3;
    localparam int DEST_W = 7;
    // Operation codes and issue slot
    localparam logic [7:0] OPC_NEQ = 8'h96;
    localparam logic [7:0] OPC_NEQ_FLAGS = 8'h97;
    localparam logic [2:0] ISSUE_SLOT = 3'h3;
    localparam int LATENCY = 1;
    // Exception flag bit positions
    localparam int FLG_INX = 1;
    localparam int FLG_UNF = 2;
    localparam int FLG_OVF = 3;
    localparam int FLG_INV = 4;
    localparam int FLG_IFZ = 5;
    localparam int FLG_OFZ = 6;
    localparam logic [FLAG_W-1:0] FLAG_MASK = 7'h7E;
    // Register offsets
    localparam logic [7:0] OFF_PSW = 8'h00;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFF_OP_COUNT = 8'h0C;
    // Event bit positions
    localparam int EV_INV = 0;
    localparam int EV_IFZ = 1;
    localparam int EV_REJECT = 2;
    // Reset values
    localparam logic [FLAG_W-1:0] RST_PSW = 7'h00;
    localparam logic [EV_W-1:0] RST_IRQ_STAT = 3'h0;
    localparam logic [EV_W-1:0] RST_IRQ_MASK = 3'h0;
    localparam logic [15:0] RST_OP_COUNT = 16'h0000;
    // Float fields
    localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
    localparam logic [7:0] EXP_ZERO = 8'h00;

    typedef struct packed {
        logic wr_en;
        logic [DEST_W-1:0] wr_dest;
        logic [WORD_W-1:0] wr_data;
        logic [FLAG_W-1:0] psw;
        logic [EV_W-1:0] irq_stat;
        logic [EV_W-1:0] irq_mask;
        logic [15:0] op_count;
        logic [WORD_W-1:0] rdata;
    } fnc_state_t;
endpackage

/* src/fnc_dp_if.sv */
// Operand path between the compare top and its datapath modules
`timescale 1ns/100ps
interface fnc_dp_if;
    logic [1:0][31:0] raw;
    logic [1:0][31:0] flat;
    logic [1:0] denorm;
    logic [1:0] snan;
    logic [1:0] qnan;
    logic ne;
    logic invalid_flag;
    modport top (output raw, input flat, denorm, snan, qnan, ne, invalid_flag);
    modport flush (input raw, output flat, denorm, snan, qnan);
    modport cmp (input flat, snan, qnan, output ne, invalid_flag);
endinterface

/* src/fnc_flush.sv */
// Operand classification and denormal flush
`timescale 1ns/100ps
module fnc_flush
    import fnc_pkg::*;
(
    fnc_dp_if.flush dp
);
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_opnd
            logic is_den;
            logic is_nan;
            assign is_den = (dp.raw[i][30:23] == EXP_ZERO) &&
                            (dp.raw[i][22:0] != 23'h000000);
            assign is_nan = (dp.raw[i][30:23] == EXP_ALL_ONES) &&
                            (dp.raw[i][22:0] != 23'h000000);
            // Denormal replaced by zero of the same sign
            assign dp.flat[i] = is_den ? {dp.raw[i][31], 31'h00000000}
                                       : dp.raw[i];
            assign dp.denorm[i] = is_den;
            assign dp.qnan[i] = is_nan && dp.raw[i][22];
            assign dp.snan[i] = is_nan && !dp.raw[i][22];
        end
    endgenerate
endmodule

/* src/fnc_cmp.sv */
// Single-precision not-equal decision
`timescale 1ns/100ps
module fnc_cmp
    import fnc_pkg::*;
(
    fnc_dp_if.cmp dp
);
    logic any_nan;
    logic both_zero;
    assign any_nan = |(dp.snan | dp.qnan);
    // Plus and minus zero are the same value
    assign both_zero = (dp.flat[0][30:0] == 31'h00000000) &&
                       (dp.flat[1][30:0] == 31'h00000000);
    // Values differ as floats; a NaN operand yields 0
    assign dp.ne = !any_nan && !both_zero && (dp.flat[0] != dp.flat[1]);
    // Only a signalling NaN raises invalid
    assign dp.invalid_flag = |dp.snan;
endmodule

/* src/fnc_unit.sv */
// Float not-equal compare unit with status word and register port
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module fnc_unit
    import fnc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic issue_valid_i,
    input wire logic [2:0] issue_slot_i,
    input wire logic [7:0] opcode_i,
    input wire logic [WORD_W-1:0] guard_i,
    input wire logic [WORD_W-1:0] first_source_i,
    input wire logic [WORD_W-1:0] second_source_i,
    input wire logic [DEST_W-1:0] dest_i,
    input wire logic [FLAG_W-1:0] other_flags_i,
    input wire logic [7:0] addr_i,
    input wire logic [WORD_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [WORD_W-1:0] rdata_o,
    output logic wr_en_o,
    output logic [DEST_W-1:0] wr_dest_o,
    output logic [WORD_W-1:0] wr_data_o,
    output logic [FLAG_W-1:0] processor_status_word_o,
    output logic irq_o
);
    fnc_state_t cur;
    fnc_state_t nxt;
    fnc_dp_if dp ();

    logic is_ours;
    logic slot_ok;
    logic acc_neq;
    logic acc_flags;
    logic guard_on;
    logic commit_neq;
    logic commit_flags;
    logic reject;
    logic [FLAG_W-1:0] op_flags;
    logic [FLAG_W-1:0] own_set;
    logic [EV_W-1:0] events;
    logic psw_wr;
    logic stat_wr;
    logic mask_wr;
    logic irq_stat_set_reject;

    assign dp.raw = {second_source_i, first_source_i};

    fnc_flush u_flush (
        .dp(dp)
    );

    fnc_cmp u_cmp (
        .dp(dp)
    );

    // Issue decode
    assign is_ours = issue_valid_i &&
                     ((opcode_i == OPC_NEQ) || (opcode_i == OPC_NEQ_FLAGS));
    assign slot_ok = (issue_slot_i == ISSUE_SLOT);
    assign acc_neq = is_ours && slot_ok && (opcode_i == OPC_NEQ);
    assign acc_flags = is_ours && slot_ok &&
                       (opcode_i == OPC_NEQ_FLAGS);
    assign reject = is_ours && !slot_ok;
    assign guard_on = guard_i[0];
    assign commit_neq = acc_neq && guard_on;
    assign commit_flags = acc_flags && guard_on;

    // Exception vector in status-word layout
    always_comb begin
        op_flags = '0;
        op_flags[FLG_IFZ] = |dp.denorm;
        op_flags[FLG_INV] = dp.invalid_flag;
    end

    // Only the compare itself feeds the status word
    assign own_set = commit_neq ? op_flags : '0;

    always_comb begin
        events = '0;
        events[EV_INV] = commit_neq && op_flags[FLG_INV];
        events[EV_IFZ] = commit_neq && op_flags[FLG_IFZ];
        events[EV_REJECT] = reject;
    end

    assign psw_wr = wr_i && (addr_i == OFF_PSW);
    assign stat_wr = wr_i && (addr_i == OFF_IRQ_STAT);
    assign mask_wr = wr_i && (addr_i == OFF_IRQ_MASK);

    always_comb begin
        nxt = cur;
        // Result leaves one cycle after issue
        nxt.wr_en = commit_neq || commit_flags;
        if (commit_neq || commit_flags) begin
            nxt.wr_dest = dest_i;
        end
        if (commit_neq) begin
            nxt.wr_data = {31'h00000000, dp.ne};
        end else if (commit_flags) begin
            nxt.wr_data = {25'h0000000, op_flags};
        end
        // Explicit write may clear; all sets OR in on top
        nxt.psw = (psw_wr ? wdata_i[FLAG_W-1:0] : cur.psw) |
                  other_flags_i | own_set;
        nxt.psw = nxt.psw & FLAG_MASK;
        // Sticky events; a new event beats a write-one clear
        nxt.irq_stat = (stat_wr ? (cur.irq_stat & ~wdata_i[EV_W-1:0])
                                : cur.irq_stat) | events;
        if (mask_wr) begin
            nxt.irq_mask = wdata_i[EV_W-1:0];
        end
        if (nxt.wr_en) begin
            nxt.op_count = cur.op_count + 16'h0001;
        end
        nxt.rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                OFF_PSW: begin
                    nxt.rdata = {25'h0000000, cur.psw};
                end
                OFF_IRQ_STAT: begin
                    nxt.rdata = {29'h00000000, cur.irq_stat};
                end
                OFF_IRQ_MASK: begin
                    nxt.rdata = {29'h00000000, cur.irq_mask};
                end
                OFF_OP_COUNT: begin
                    nxt.rdata = {16'h0000, cur.op_count};
                end
                default: begin
                    nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur.wr_en <= 1'b0;
            cur.wr_dest <= '0;
            cur.wr_data <= '0;
            cur.psw <= RST_PSW;
            cur.irq_stat <= RST_IRQ_STAT;
            cur.irq_mask <= RST_IRQ_MASK;
            cur.op_count <= RST_OP_COUNT;
            cur.rdata <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign wr_en_o = cur.wr_en;
    assign wr_dest_o = cur.wr_dest;
    assign wr_data_o = cur.wr_data;
    assign processor_status_word_o = cur.psw;
    assign rdata_o = cur.rdata;
    assign irq_o = |(cur.irq_stat & cur.irq_mask);

    // Checks
    AST_NE_VALUE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq |=> wr_en_o && (wr_data_o[0] == $past(dp.ne)))
    else $error("compare result does not match operand difference");

    AST_NE_EQUAL_OPS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq && (first_source_i == second_source_i) &&
        !(|dp.snan) && !(|dp.qnan)
        |=> wr_data_o == 32'h00000000)
    else $error("equal operands did not give zero");

    AST_IFZ_TO_PSW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq && (|dp.denorm) |=> processor_status_word_o[FLG_IFZ])
    else $error("input flush not recorded in status word");

    AST_INV_TO_PSW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq && dp.invalid_flag |=> processor_status_word_o[FLG_INV])
    else $error("invalid not recorded in status word");

    AST_STICKY: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !psw_wr |=> ((processor_status_word_o &
                      $past(processor_status_word_o)) ==
                     $past(processor_status_word_o)))
    else $error("status flag dropped without a status write");

    AST_SAME_CYCLE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq && (|op_flags) |=>
        wr_en_o && ((processor_status_word_o & $past(op_flags)) ==
                    $past(op_flags)))
    else $error("flag update not in the write cycle");

    AST_OR_MERGE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !psw_wr |=> processor_status_word_o ==
            (($past(processor_status_word_o) | $past(other_flags_i) |
              $past(own_set)) & FLAG_MASK))
    else $error("status word is not the OR of all updates");

    AST_GUARD_OFF: assert property (
        @(posedge clk_i) disable iff (rst_i)
        acc_neq && !guard_on && !psw_wr && (other_flags_i == 7'h00)
        |=> !wr_en_o && $stable(processor_status_word_o))
    else $error("false guard changed result or flags");

    AST_SLOT_ONLY: assert property (
        @(posedge clk_i) disable iff (rst_i)
        is_ours && !slot_ok |=> !wr_en_o ##0 irq_stat_set_reject)
    else $error("issue outside slot 3 was executed");

    assign irq_stat_set_reject = cur.irq_stat[EV_REJECT];

    AST_FLAGOP_LATENCY: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_flags |=> wr_en_o && (wr_dest_o == $past(dest_i)))
    else $error("flag operation not written after one cycle");

    AST_FLAGOP_NO_PSW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_flags && !psw_wr && (other_flags_i == 7'h00)
        |=> $stable(processor_status_word_o))
    else $error("flag operation touched the status word");

    AST_FLAGOP_LAYOUT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_flags |=> wr_data_o[FLG_INV] == $past(dp.invalid_flag) &&
                         wr_data_o[31:FLAG_W] == 25'h0000000)
    else $error("flag vector layout wrong");

    AST_FLAGOP_IFZ: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_flags && (|dp.denorm) |=> wr_data_o[FLG_IFZ])
    else $error("input flush bit missing in flag vector");

    AST_FLAGOP_GUARD: assert property (
        @(posedge clk_i) disable iff (rst_i)
        acc_flags && !guard_on |=> !wr_en_o)
    else $error("false guard wrote the flag result");

    AST_IFZ_CODE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_flags && (|dp.denorm) && !dp.invalid_flag
        |=> wr_data_o == 32'h00000020)
    else $error("input flush code is not 20 hex");

    AST_INF_PAIR: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq && (first_source_i == 32'h7F800000) &&
        (second_source_i == 32'hFF800000)
        |=> wr_data_o == 32'h00000001)
    else $error("opposite infinities reported equal");

    AST_UPPER_ZERO: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq |=> wr_data_o[31:1] == 31'h00000000)
    else $error("upper result bits not cleared");

    AST_WR_PULSE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(commit_neq || commit_flags) |=> !wr_en_o)
    else $error("result written without a committed operation");

    AST_NE_DEST: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq |=> wr_en_o && (wr_dest_o == $past(dest_i)))
    else $error("compare result went to the wrong register");

    AST_NAN_ZERO: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq && ((|dp.snan) || (|dp.qnan))
        |=> wr_data_o == 32'h00000000)
    else $error("NaN operand did not give zero");

    AST_INF_SELF: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq && (first_source_i == 32'h7F800000) &&
        (second_source_i == 32'h7F800000)
        |=> wr_data_o == 32'h00000000)
    else $error("infinity not equal to itself");

    AST_ZERO_SIGNS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_neq && (first_source_i == 32'h00000000) &&
        (second_source_i == 32'h80000000)
        |=> wr_data_o == 32'h00000000)
    else $error("plus and minus zero reported unequal");

    AST_PSW_WRITE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        psw_wr |=> processor_status_word_o ==
            (($past(wdata_i[FLAG_W-1:0]) | $past(other_flags_i) |
              $past(own_set)) & FLAG_MASK))
    else $error("status write did not merge with new flags");

    AST_FLAGOP_INV: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_flags && (|dp.snan) |=> wr_data_o[FLG_INV])
    else $error("invalid bit missing in flag vector");

    AST_FLAGOP_QUIET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        commit_flags && !(|dp.snan) && !(|dp.denorm)
        |=> wr_data_o == 32'h00000000)
    else $error("flag vector not empty for a quiet compare");

    AST_FLAGOP_HOLD: assert property (
        @(posedge clk_i) disable iff (rst_i)
        acc_flags && !guard_on |=> $stable(wr_data_o))
    else $error("false guard changed the flag result");

    AST_OTHER_SET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (|other_flags_i) |=>
        ((processor_status_word_o & $past(other_flags_i) & FLAG_MASK) ==
         ($past(other_flags_i) & FLAG_MASK)))
    else $error("flags from other units were lost");

    AST_SLOT_FLAGS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        is_ours && !slot_ok && (opcode_i == OPC_NEQ_FLAGS)
        |=> !wr_en_o)
    else $error("flag operation outside slot 3 was executed");

endmodule

/* verification/fnc_regfile_model.sv */
// Register file model that receives the unit's result writes
`timescale 1ns/100ps
module fnc_regfile_model
    import fnc_pkg::*;
(
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic [DEST_W-1:0] wr_dest_i,
    input wire logic [WORD_W-1:0] wr_data_i,
    input wire logic [DEST_W-1:0] rd_idx_i,
    output logic [WORD_W-1:0] rd_data_o,
    output logic [15:0] writes_o
);
    logic [WORD_W-1:0] regs [2**DEST_W];

    // Filler so that a missed or extra write shows up
    initial begin
        foreach (regs[i]) regs[i] = 32'h5A5A5A5A;
        writes_o = 16'h0000;
    end

    always @(posedge clk_i) begin
        if (wr_en_i === 1'b1) begin
            regs[wr_dest_i] <= wr_data_i;
            writes_o <= writes_o + 16'h0001;
        end
    end

    assign rd_data_o = regs[rd_idx_i];
endmodule

/* verification/fp_not_equal_compare_flags_tb_top.sv */
// Self-checking testbench for the float not-equal compare unit
`timescale 1ns/100ps
module fp_not_equal_compare_flags_tb_top
    import fnc_pkg::*;
();
    typedef struct packed {
        logic [7:0] op;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] res;
        logic [6:0] flg;
    } fnc_row_t;
    localparam logic [7:0] C = OPC_NEQ;
    localparam logic [7:0] F = OPC_NEQ_FLAGS;
    fnc_row_t rows [14] = '{
        '{F, 32'h40400000, 32'h00000000, 32'h00, 7'h00},
        '{F, 32'h3F800000, 32'h00400000, 32'h20, 7'h20},
        '{F, 32'h7F800000, 32'hFF800000, 32'h00, 7'h00},
        '{F, 32'h40400000, 32'h7F800001, 32'h10, 7'h10},
        '{F, 32'h40400000, 32'hFFFFFFFF, 32'h00, 7'h00},
        '{C, 32'h40400000, 32'h00000000, 32'h01, 7'h00},
        '{C, 32'h40400000, 32'h40400000, 32'h00, 7'h00},
        '{C, 32'h3F800000, 32'h40400000, 32'h01, 7'h00},
        '{C, 32'h7F800000, 32'hFF800000, 32'h01, 7'h00},
        '{C, 32'h7F800000, 32'h7F800000, 32'h00, 7'h00},
        '{C, 32'h00000000, 32'h80000000, 32'h00, 7'h00},
        '{C, 32'h40400000, 32'hFFFFFFFF, 32'h00, 7'h00},
        '{C, 32'h3F800000, 32'h00400000, 32'h01, 7'h20},
        '{C, 32'h7F800001, 32'h40400000, 32'h00, 7'h10}};
    logic clk = 0, rst = 1, issue_valid = 0, wr = 0, rd = 0;
    logic [2:0] issue_slot = 3'h3;
    logic [7:0] opcode = 8'h00, addr = 8'h00;
    logic [31:0] guard = 0, src_a = 0, src_b = 0, wdata = 0;
    logic [6:0] dest = 0, other_flags = 0, rd_idx = 0, exp_psw = 0;
    logic [31:0] rdata, wr_data, rd_data;
    logic [6:0] wr_dest, psw;
    logic wr_en, irq;
    logic [15:0] writes;
    int num_errors = 0, compares = 0, cycles = 0;

    always #25 clk = ~clk;

    fnc_unit i_dut (.clk_i(clk), .rst_i(rst), .issue_valid_i(issue_valid),
        .issue_slot_i(issue_slot), .opcode_i(opcode), .guard_i(guard),
        .first_source_i(src_a), .second_source_i(src_b), .dest_i(dest),
        .other_flags_i(other_flags), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .wr_en_o(wr_en),
        .wr_dest_o(wr_dest), .wr_data_o(wr_data),
        .processor_status_word_o(psw), .irq_o(irq));
    fnc_regfile_model i_rf (.clk_i(clk), .wr_en_i(wr_en),
        .wr_dest_i(wr_dest), .wr_data_i(wr_data), .rd_idx_i(rd_idx),
        .rd_data_o(rd_data), .writes_o(writes));

    task automatic check(input logic [63:0] got, exp, input string msg);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic issue(input logic [7:0] op, input logic [2:0] slot,
            input logic [31:0] g, a, b, input logic [6:0] d, oth);
        @(posedge clk);
        issue_valid <= 1;
        opcode <= op;
        issue_slot <= slot;
        guard <= g;
        src_a <= a;
        src_b <= b;
        dest <= d;
        other_flags <= oth;
        @(posedge clk);
        issue_valid <= 0;
        other_flags <= 0;
        #1;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1;
        check(rdata, exp, "register read");
    endtask

    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        #1;
        check({wr_en, irq, psw, rdata}, 0, "reset outputs");
        check({wr_dest, wr_data}, 0, "reset result");
        foreach (rows[i]) begin
            issue(rows[i].op, 3'h3, 32'h1, rows[i].a, rows[i].b,
                7'(i + 10), 7'h00);
            if (rows[i].op == C)
                exp_psw = exp_psw | rows[i].flg;
            check(wr_en, 1, "write pulse");
            check(wr_dest, i + 10, "destination");
            check(wr_data, rows[i].res, "result");
            check(psw, exp_psw, "status word");
        end
        issue(C, 3'h3, 32'h1, 32'h40400000, 0, 7'h01, 7'h00);
        check(psw, 7'h30, "sticky flags");
        bus_wr(OFF_PSW, 0);
        bus_rd(OFF_PSW, 0);
        // Back-to-back compare and flag operation
        @(posedge clk);
        issue_valid <= 1;
        opcode <= C;
        src_a <= 32'h40400000;
        src_b <= 0;
        dest <= 7'h02;
        @(posedge clk);
        opcode <= F;
        src_b <= 32'h00400000;
        dest <= 7'h03;
        #1;
        check({wr_dest, wr_data}, {7'h02, 32'h1}, "first of pair");
        @(posedge clk);
        issue_valid <= 0;
        #1;
        check({wr_dest, wr_data}, {7'h03, 32'h20}, "pair");
        check(psw, 0, "flag op left status");
        rd_idx = 7'h33;
        issue(C, 3'h3, 32'hFFFFFFFE, 32'h3F800000, 32'h00400000, 7'h33, 0);
        check({wr_en, psw}, 0, "guard false");
        issue(F, 3'h3, 32'h0, 32'h3F800000, 32'h00400000, 7'h33, 0);
        check(wr_en, 0, "flag guard false");
        @(posedge clk);
        #1;
        check(rd_data, 32'h5A5A5A5A, "untouched register");
        issue(C, 3'h3, 32'h1, 32'h3F800000, 32'h00400000, 7'h04, 7'h06);
        check(psw, 7'h26, "merged flags");
        issue(C, 3'h2, 32'h1, 32'h3F800000, 32'h40400000, 7'h05, 0);
        check(wr_en, 0, "wrong slot");
        issue(8'h98, 3'h3, 32'h1, 32'h3F800000, 32'h40400000, 7'h05, 0);
        check(wr_en, 0, "foreign opcode");
        issue(F, 3'h2, 32'h1, 32'h3F800000, 32'h00400000, 7'h05, 0);
        check(wr_en, 0, "flag op wrong slot");
        // Status write in the same cycle as a set from another unit
        @(posedge clk);
        wr <= 1;
        addr <= OFF_PSW;
        wdata <= 32'h00000003;
        other_flags <= 7'h08;
        @(posedge clk);
        wr <= 0;
        other_flags <= 7'h00;
        #1;
        check(psw, 7'h0A, "write with set");
        check(writes, 18, "register file writes");
        bus_rd(OFF_OP_COUNT, 18);
        bus_rd(8'h10, 0);
        bus_rd(OFF_IRQ_STAT, 7);
        check(irq, 0, "masked interrupt");
        bus_wr(OFF_IRQ_MASK, 7);
        check(irq, 1, "interrupt raised");
        bus_wr(OFF_IRQ_STAT, 7);
        check(irq, 0, "interrupt cleared");
        bus_rd(OFF_IRQ_STAT, 0);
        bus_rd(OFF_IRQ_MASK, 7);
        // Reset in mid-run
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        #1;
        check({wr_en, irq, psw, rdata}, 0, "reset outputs again");
        check({wr_dest, wr_data}, 0, "reset result again");
        bus_rd(OFF_IRQ_MASK, 0);
        bus_rd(OFF_OP_COUNT, 0);
        print_verdict();
    end
endmodule
